/* verilog/usb_port_cfg.svh */
// offsets, field positions, reset values and timing counts of the usb device port
`ifndef USB_PORT_CFG_SVH
`define USB_PORT_CFG_SVH

`define NUM_ENDPOINTS 6
`define CLK_FREQ_MHZ 100
`define SUSPEND_IDLE_US 3000
`define SUSPEND_IDLE_CYCLES (`SUSPEND_IDLE_US * `CLK_FREQ_MHZ)

`define OFS_INT_STATUS 8'h00
`define OFS_INT_MASK 8'h04
`define OFS_INT_CLEAR 8'h08
`define OFS_EP_FIFO_RESET 8'h0c
`define OFS_PORT_CTRL 8'h10
`define OFS_EP_CSR_BASE 8'h20

`define INT_MASK_RESET 32'h0000_0200

`define BIT_SUSPEND 8
`define BIT_BUS_RESUME 9
`define BIT_LOCAL_RESUME 10
`define BIT_FRAME_START 11
`define BIT_BUS_RESET_DONE 12
`define BIT_WAKEUP 13

`define CTRL_REMOTE_WAKEUP 0
`define CTRL_SUSPENDED 1

`define CSR_TX_COMPLETE 0
`define CSR_RX_BANK_A 1
`define CSR_SETUP 2
`define CSR_STALL_ACK 3
`define CSR_KIND_LO 8
`define CSR_KIND_HI 10
`define CSR_TOGGLE 11
`define CSR_ENABLE 15
`define CSR_COUNT_LO 16
`define CSR_COUNT_HI 26
`define CSR_RW_MASK 32'h0000_8700

`endif

/* verilog/usb_port_pkg.sv */
// shared types of the usb device port
package usb_port_pkg;
  typedef logic [2:0] ep_kind_t;
  typedef logic [10:0] byte_count_t;
  typedef enum logic [1:0]
  {
    resp_okay = 2'h0,
    resp_slverr = 2'h2
  } axi_resp_t;
  typedef enum logic {wr_idle, wr_answer} wr_state_t;
endpackage

/* verilog/usb_ep_if.sv */
// signals between the register side and one endpoint flag block
`timescale 1ns/1ps
interface usb_ep_if;
  logic in_acked;
  logic data_stored;
  logic setup_stored;
  logic stall_acked;
  logic crc_fault;
  usb_port_pkg::byte_count_t stored_bytes;
  logic csr_write;
  logic [31:0] csr_wdata;
  logic [31:0] csr_wmask;
  logic fifo_reset;
  logic [31:0] csr_rdata;
  logic ep_irq;
  logic accept_out;
  logic fifo_clear;
  modport regs
  (
    output in_acked, data_stored, setup_stored, stall_acked, crc_fault, stored_bytes,
    output csr_write, csr_wdata, csr_wmask, fifo_reset,
    input csr_rdata, ep_irq, accept_out, fifo_clear
  );
  modport ep
  (
    input in_acked, data_stored, setup_stored, stall_acked, crc_fault, stored_bytes,
    input csr_write, csr_wdata, csr_wmask, fifo_reset,
    output csr_rdata, ep_irq, accept_out, fifo_clear
  );
endinterface

/* verilog/usb_ep_flags.sv */
// handshake flags, byte count and data toggle of one endpoint
`timescale 1ns/1ps
`include "usb_port_cfg.svh"
module usb_ep_flags
(
  input wire logic sys_clk,
  input wire logic srst,
  usb_ep_if.ep bus
);
  logic tx_complete;
  logic receive_bank_a;
  logic setup_received;
  logic stall_acknowledged;
  logic data_toggle;
  logic endpoint_on;
  usb_port_pkg::ep_kind_t endpoint_kind;
  usb_port_pkg::byte_count_t received_byte_count;
  logic is_iso;
  logic out_taken;
  logic [31:0] zero_wr;

  assign is_iso = endpoint_kind[1:0] == 2'h1;
  // bits written as zero under an enabled lane
  assign zero_wr = bus.csr_write ? (bus.csr_wmask & ~bus.csr_wdata) : 32'h0;
  // no out data while setup pending
  assign bus.accept_out = !setup_received;
  assign out_taken = bus.data_stored && !setup_received;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      tx_complete <= 1'b0;
    else if (bus.in_acked)
      tx_complete <= 1'b1;
    else if (zero_wr[`CSR_TX_COMPLETE])
      tx_complete <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      receive_bank_a <= 1'b0;
    else if (out_taken)
      receive_bank_a <= 1'b1;
    else if (zero_wr[`CSR_RX_BANK_A])
      receive_bank_a <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      setup_received <= 1'b0;
    else if (bus.setup_stored)
      setup_received <= 1'b1;
    else if (zero_wr[`CSR_SETUP])
      setup_received <= 1'b0;
  end

  // stall ack or iso crc fault
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      stall_acknowledged <= 1'b0;
    else if (is_iso ? bus.crc_fault : bus.stall_acked)
      stall_acknowledged <= 1'b1;
    else if (zero_wr[`CSR_STALL_ACK])
      stall_acknowledged <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      endpoint_kind <= 3'h0;
      endpoint_on <= 1'b0;
    end
    else if (bus.csr_write)
    begin
      if (bus.csr_wmask[`CSR_KIND_LO])
        endpoint_kind <= bus.csr_wdata[`CSR_KIND_HI:`CSR_KIND_LO];
      if (bus.csr_wmask[`CSR_ENABLE])
        endpoint_on <= bus.csr_wdata[`CSR_ENABLE];
    end
  end

  // fifo reset zeroes count and toggle
  always_ff @(posedge sys_clk)
  begin
    if (srst || bus.fifo_reset)
    begin
      received_byte_count <= 11'h000;
      data_toggle <= 1'b0;
    end
    else
    begin
      if (out_taken || bus.setup_stored)
        received_byte_count <= bus.stored_bytes;
      if (out_taken || bus.in_acked)
        data_toggle <= !data_toggle;
    end
  end

  assign bus.fifo_clear = bus.fifo_reset;
  // endpoint irq while any flag set
  assign bus.ep_irq = tx_complete | receive_bank_a | setup_received | stall_acknowledged;

  always_comb
  begin
    bus.csr_rdata = 32'h0;
    bus.csr_rdata[`CSR_TX_COMPLETE] = tx_complete;
    bus.csr_rdata[`CSR_RX_BANK_A] = receive_bank_a;
    bus.csr_rdata[`CSR_SETUP] = setup_received;
    bus.csr_rdata[`CSR_STALL_ACK] = stall_acknowledged;
    bus.csr_rdata[`CSR_KIND_HI:`CSR_KIND_LO] = endpoint_kind;
    bus.csr_rdata[`CSR_TOGGLE] = data_toggle;
    bus.csr_rdata[`CSR_ENABLE] = endpoint_on;
    bus.csr_rdata[`CSR_COUNT_HI:`CSR_COUNT_LO] = received_byte_count;
  end

  a_setup_blocks_out: assert property (@(posedge sys_clk) disable iff (srst)
    setup_received && bus.data_stored && !receive_bank_a |=> !receive_bank_a)
    else $error("out data taken while setup pending");
  a_reset_zero_count: assert property (@(posedge sys_clk) disable iff (srst)
    bus.fifo_reset |=> received_byte_count == 11'h000 && !data_toggle)
    else $error("count or toggle not zero under fifo reset");
  a_transmit_complete_set_wins: assert property (@(posedge sys_clk) disable iff (srst)
    bus.in_acked ##1 1'b1 |-> tx_complete)
    else $error("transmit complete lost");
  a_bank_write_one: assert property (@(posedge sys_clk) disable iff (srst)
    receive_bank_a && bus.csr_write && bus.csr_wmask[1] && bus.csr_wdata[1]
    |=> receive_bank_a)
    else $error("write one cleared bank flag");
  a_reset_keeps_flags: assert property (@(posedge sys_clk) disable iff (srst)
    bus.fifo_reset && !bus.csr_write && tx_complete |=> tx_complete)
    else $error("fifo reset cleared a flag");
endmodule

/* verilog/usb_device_port.sv */
// event flags, endpoint flags and axi4-lite registers of the usb device port
//
// Overview of operation
// - host resume at port sets resume flag
// - suspended local resume edge sets flag
// - with remote wakeup, drive bus resume
// - every frame start token sets flag
// - bus reset end sets done flag
// - host resume or reset sets wakeup
// - clear register bits 8-13 clear flags
// - endpoint reset clears fifo, count, toggle
// - software ends reset; flags kept
// - reset held forces count to zero
// - in ack sets transmit complete
// - stored packet sets bank a flag
// - valid setup sets setup flag
// - no out data while setup set
// - stall ack sets flag until cleared
// - iso endpoints report crc fault there
// - idle 3ms sets suspend flag, suspends
// - endpoint irq stays while flags set
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "usb_port_cfg.svh"
module usb_device_port
#(
  parameter int SUSPEND_CYCLES = `SUSPEND_IDLE_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic bus_activity,
  input wire logic host_resume_seen,
  input wire logic frame_start_seen,
  input wire logic bus_reset_seen,
  input wire logic local_resume_request,
  input wire logic [5:0] ep_in_acked,
  input wire logic [5:0] ep_data_stored,
  input wire logic [5:0] ep_setup_stored,
  input wire logic [5:0] ep_stall_acked,
  input wire logic [5:0] ep_crc_fault,
  input wire logic [65:0] ep_stored_bytes,
  output logic [5:0] ep_accept_out,
  output logic [5:0] ep_fifo_clear,
  output logic suspended,
  output logic send_resume,
  output logic irq
);
  localparam int NEP = `NUM_ENDPOINTS;
  localparam int IDLE_W = $clog2(SUSPEND_CYCLES + 1);

  usb_ep_if ep_bus [NEP] ();

  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  usb_port_pkg::wr_state_t wr_state;
  logic wr_fire;
  logic wr_hit;
  logic [31:0] wmask;
  logic [31:0] clr_bits;
  logic [13:8] event_flags;
  logic [13:8] next_event_flags;
  logic [13:8] event_set;
  logic [31:0] int_mask;
  logic [5:0] endpoint_fifo_reset;
  logic remote_wakeup_enable;
  logic [IDLE_W-1:0] idle_count;
  logic resume_meta;
  logic resume_sync;
  logic resume_prev;
  logic local_edge;
  logic [5:0] ep_irq_vec;
  logic [31:0] int_status;
  logic [31:0] ep_rdata [NEP];

  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  function automatic logic is_ep_addr(input logic [7:0] a);
    is_ep_addr = a >= `OFS_EP_CSR_BASE && a < `OFS_EP_CSR_BASE + 8'(4 * NEP);
  endfunction

  function automatic logic is_mapped(input logic [7:0] a, input logic wr);
    is_mapped = a == `OFS_INT_MASK || a == `OFS_EP_FIFO_RESET || a == `OFS_PORT_CTRL
      || is_ep_addr(a) || (wr ? a == `OFS_INT_CLEAR : a == `OFS_INT_STATUS);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign wr_fire = aw_held && w_held && wr_state == usb_port_pkg::wr_idle;
  assign wr_hit = wr_fire && is_mapped(aw_addr, 1'b1);
  assign wmask = lane_mask(w_strb);
  assign s_axi_bvalid = wr_state == usb_port_pkg::wr_answer;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held <= 1'b1;
      aw_addr <= {s_axi_awaddr[7:2], 2'h0};
    end
    else if (wr_fire)
      aw_held <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      w_held <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
    else if (wr_fire)
      w_held <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      wr_state <= usb_port_pkg::wr_idle;
      s_axi_bresp <= usb_port_pkg::resp_okay;
    end
    else
    begin
      unique case (wr_state)
        usb_port_pkg::wr_idle:
          if (wr_fire)
          begin
            wr_state <= usb_port_pkg::wr_answer;
            s_axi_bresp <= wr_hit ? usb_port_pkg::resp_okay : usb_port_pkg::resp_slverr;
          end
        usb_port_pkg::wr_answer:
          if (s_axi_bready)
            wr_state <= usb_port_pkg::wr_idle;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= usb_port_pkg::resp_okay;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= is_mapped(s_axi_araddr[7:0], 1'b0) ? usb_port_pkg::resp_okay
        : usb_port_pkg::resp_slverr;
      if (is_ep_addr(s_axi_araddr[7:0]))
        s_axi_rdata <= ep_rdata[3'(s_axi_araddr[7:2] - `OFS_EP_CSR_BASE / 4)];
      else
        unique case (s_axi_araddr[7:0])
          `OFS_INT_STATUS: s_axi_rdata <= int_status;
          `OFS_INT_MASK: s_axi_rdata <= int_mask;
          `OFS_EP_FIFO_RESET: s_axi_rdata <= {26'h0, endpoint_fifo_reset};
          `OFS_PORT_CTRL: s_axi_rdata <= {30'h0, suspended, remote_wakeup_enable};
          default: s_axi_rdata <= 32'h0;
        endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // software controls

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      int_mask <= `INT_MASK_RESET;
    else if (wr_hit && aw_addr == `OFS_INT_MASK)
      int_mask <= 32'h0000_3f3f & ((int_mask & ~wmask) | (w_data & wmask));
  end

  // reset bits held until software clears
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      endpoint_fifo_reset <= 6'h00;
    else if (wr_hit && aw_addr == `OFS_EP_FIFO_RESET && w_strb[0])
      endpoint_fifo_reset <= w_data[5:0];
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      remote_wakeup_enable <= 1'b0;
    else if (wr_hit && aw_addr == `OFS_PORT_CTRL && w_strb[0])
      remote_wakeup_enable <= w_data[`CTRL_REMOTE_WAKEUP];
  end

  ////////////////////////////////////////////////////////////////////////////
  // local resume request, pin synchroniser

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      resume_meta <= 1'b0;
      resume_sync <= 1'b0;
      resume_prev <= 1'b0;
    end
    else
    begin
      resume_meta <= local_resume_request;
      resume_sync <= resume_meta;
      resume_prev <= resume_sync;
    end
  end

  // rising edge only counts while suspended
  assign local_edge = resume_sync && !resume_prev && suspended;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      send_resume <= 1'b0;
    else
      send_resume <= local_edge && remote_wakeup_enable;
  end

  ////////////////////////////////////////////////////////////////////////////
  // suspend detection

  // idle for the full count suspends
  always_ff @(posedge sys_clk)
  begin
    if (srst || bus_activity)
      idle_count <= '0;
    else if (idle_count != IDLE_W'(SUSPEND_CYCLES))
      idle_count <= idle_count + 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst || bus_activity || host_resume_seen || bus_reset_seen)
      suspended <= 1'b0;
    else if (idle_count == IDLE_W'(SUSPEND_CYCLES - 1))
      suspended <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus event flags

  always_comb
  begin
    event_set = '0;
    event_set[`BIT_SUSPEND] = !srst && idle_count == IDLE_W'(SUSPEND_CYCLES - 1) && !bus_activity;
    event_set[`BIT_BUS_RESUME] = host_resume_seen;
    event_set[`BIT_LOCAL_RESUME] = local_edge;
    event_set[`BIT_FRAME_START] = frame_start_seen;
    event_set[`BIT_BUS_RESET_DONE] = bus_reset_seen;
    event_set[`BIT_WAKEUP] = host_resume_seen || bus_reset_seen;
  end

  assign clr_bits = (wr_hit && aw_addr == `OFS_INT_CLEAR) ? (w_data & wmask) : 32'h0;
  assign next_event_flags = event_set | (event_flags & ~clr_bits[13:8]);

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      event_flags <= '0;
    else
      event_flags <= next_event_flags;
  end

  ////////////////////////////////////////////////////////////////////////////
  // endpoints

  for (genvar i = 0; i < NEP; i++)
  begin : g_ep
    assign ep_bus[i].in_acked = ep_in_acked[i];
    assign ep_bus[i].data_stored = ep_data_stored[i];
    assign ep_bus[i].setup_stored = ep_setup_stored[i];
    assign ep_bus[i].stall_acked = ep_stall_acked[i];
    assign ep_bus[i].crc_fault = ep_crc_fault[i];
    assign ep_bus[i].stored_bytes = ep_stored_bytes[11*i +: 11];
    assign ep_bus[i].csr_write = wr_hit && aw_addr == `OFS_EP_CSR_BASE + 8'(4 * i);
    assign ep_bus[i].csr_wdata = w_data;
    assign ep_bus[i].csr_wmask = wmask;
    assign ep_bus[i].fifo_reset = endpoint_fifo_reset[i];
    assign ep_rdata[i] = ep_bus[i].csr_rdata;
    assign ep_irq_vec[i] = ep_bus[i].ep_irq;
    assign ep_accept_out[i] = ep_bus[i].accept_out;
    assign ep_fifo_clear[i] = ep_bus[i].fifo_clear;
    usb_ep_flags u_ep
    (
      .sys_clk(sys_clk),
      .srst(srst),
      .bus(ep_bus[i])
    );
  end

  assign int_status = {18'h0, event_flags, 2'h0, ep_irq_vec};
  assign irq = |(int_status & int_mask);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_clear_event_flag: assert property (@(posedge sys_clk) disable iff (srst)
    wr_hit && aw_addr == `OFS_INT_CLEAR && w_strb[1] && w_data[11] && !frame_start_seen
    |=> !event_flags[`BIT_FRAME_START])
    else $error("frame start flag not cleared");
  a_frame_start_set: assert property (@(posedge sys_clk) disable iff (srst)
    frame_start_seen |=> event_flags[`BIT_FRAME_START])
    else $error("frame start flag not set");
  a_wakeup_on_reset: assert property (@(posedge sys_clk) disable iff (srst)
    bus_reset_seen |=> event_flags[`BIT_WAKEUP] && event_flags[`BIT_BUS_RESET_DONE])
    else $error("wakeup or reset done missing");
  a_remote_wake_out: assert property (@(posedge sys_clk) disable iff (srst)
    send_resume |-> $past(remote_wakeup_enable) && event_flags[`BIT_LOCAL_RESUME])
    else $error("resume driven without cause");
  a_irq_follows_mask: assert property (@(posedge sys_clk) disable iff (srst)
    (event_flags & int_mask[13:8]) != 6'h00 |-> irq)
    else $error("enabled event flag without irq");
  a_suspend_after_idle: assert property (@(posedge sys_clk) disable iff (srst)
    $rose(suspended) |-> event_flags[`BIT_SUSPEND] && idle_count == IDLE_W'(SUSPEND_CYCLES))
    else $error("suspend without full idle time");
  a_ext_resume_flag: assert property (@(posedge sys_clk) disable iff (srst)
    $rose(event_flags[`BIT_LOCAL_RESUME]) |-> $past(suspended) && resume_prev)
    else $error("local resume flag without suspended edge");
endmodule

/* test/usb_host_model.sv */
// host-side event model driving the bus and endpoint event inputs
`timescale 1ns/1ps
module usb_host_model
(
  input wire logic sys_clk,
  output logic bus_activity,
  output logic host_resume_seen,
  output logic frame_start_seen,
  output logic bus_reset_seen,
  output logic [5:0] ep_in_acked,
  output logic [5:0] ep_data_stored,
  output logic [5:0] ep_setup_stored,
  output logic [5:0] ep_stall_acked,
  output logic [5:0] ep_crc_fault,
  output logic [65:0] ep_stored_bytes
);
  logic [7:0] sel = 8'h00;
  logic [5:0] eps = 6'h00;
  assign host_resume_seen = sel[0];
  assign frame_start_seen = sel[1];
  assign bus_reset_seen = sel[2];
  assign ep_in_acked = sel[3] ? eps : 6'h00;
  assign ep_data_stored = sel[4] ? eps : 6'h00;
  assign ep_setup_stored = sel[5] ? eps : 6'h00;
  assign ep_stall_acked = sel[6] ? eps : 6'h00;
  assign ep_crc_fault = sel[7] ? eps : 6'h00;
  initial
  begin
    bus_activity = 1'b1;
    ep_stored_bytes = 66'h0;
  end
  task automatic pulse(input int s, input logic [5:0] e, input logic [10:0] n);
    sel <= 8'h01 << s;
    eps <= e;
    ep_stored_bytes <= {6{n}};
    @(posedge sys_clk);
    sel <= 8'h00;
    // count lines no longer hold the last value once released
    ep_stored_bytes <= {6{~n}};
    @(posedge sys_clk);
  endtask
  task automatic go_quiet(input logic q);
    bus_activity <= !q;
  endtask
endmodule

/* test/usb_device_event_endpoint_flags_tb.sv */
// register-level bench of the usb device port event and endpoint flags
`timescale 1ns/1ps
`include "usb_port_cfg.svh"
module usb_device_event_endpoint_flags_tb;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, local_resume_request = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic bus_activity, host_resume_seen, frame_start_seen, bus_reset_seen;
  logic [5:0] ep_in_acked, ep_data_stored, ep_setup_stored, ep_stall_acked, ep_crc_fault;
  logic [5:0] ep_accept_out, ep_fifo_clear;
  logic [65:0] ep_stored_bytes;
  logic suspended, send_resume, irq;
  logic [31:0] rd;
  logic [31:0] ev_exp [3] = '{32'h0000_2200, 32'h0000_0800, 32'h0000_3000};
  int bad_count = 0, n_compared = 0, n_wake = 0;

  usb_device_port #(.SUSPEND_CYCLES(20)) DUT (.*);
  usb_host_model host (.*);

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (send_resume === 1'b1) n_wake <= n_wake + 1;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // handshakes judged on values settled before the edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(negedge sys_clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge sys_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    while (!tb);
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(negedge sys_clk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge sys_clk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    while (!tr);
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] m, exp);
    axi_rd(a, rd, rs);
    check(n, rd & m, exp);
  endtask

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    bad_count++;
    finish_test();
  end

  initial
  begin
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    rchk("status at reset", `OFS_INT_STATUS, 32'hffff_ffff, 32'h0);
    rchk("mask at reset", `OFS_INT_MASK, 32'hffff_ffff, `INT_MASK_RESET);
    axi_wr(`OFS_INT_CLEAR, 32'h0000_3f00, rs);
    axi_rd(`OFS_INT_CLEAR, rd, rs);
    check("clear read resp", 32'(rs), 32'(usb_port_pkg::resp_slverr));
    axi_wr(8'h1c, 32'h1, rs);
    check("unmapped resp", 32'(rs), 32'(usb_port_pkg::resp_slverr));
    axi_wr(`OFS_INT_MASK, 32'h0000_3f3f, rs);
    // host resume, frame start, end of bus reset
    for (int i = 0; i < 3; i++)
    begin
      host.pulse(i, 6'h00, 11'h0);
      rchk("bus event", `OFS_INT_STATUS, 32'hffff_ffff, ev_exp[i]);
      check("irq set", 32'(irq), 32'h1);
      axi_wr(`OFS_INT_CLEAR, 32'h0, rs);
      rchk("zero clear", `OFS_INT_STATUS, 32'hffff_ffff, ev_exp[i]);
      axi_wr(`OFS_INT_CLEAR, ev_exp[i], rs);
      rchk("cleared", `OFS_INT_STATUS, 32'hffff_ffff, 32'h0);
      check("irq clear", 32'(irq), 32'h0);
    end
    host.pulse(3, 6'h02, 11'h0);
    rchk("in ack", 8'h24, 32'h80f, 32'h801);
    rchk("ep irq", `OFS_INT_STATUS, 32'h3f, 32'h2);
    axi_wr(8'h24, 32'hf, rs);
    rchk("one kept", 8'h24, 32'hf, 32'h1);
    axi_wr(8'h24, 32'h0, rs);
    rchk("tx cleared", 8'h24, 32'hf, 32'h0);
    rchk("ep irq off", `OFS_INT_STATUS, 32'h3f, 32'h0);
    host.pulse(4, 6'h02, 11'h005);
    rchk("bank stored", 8'h24, 32'h07ff_000f, 32'h0005_0002);
    axi_wr(8'h24, 32'h2, rs);
    rchk("bank one kept", 8'h24, 32'h07ff_000f, 32'h0005_0002);
    host.pulse(5, 6'h02, 11'h008);
    rchk("setup stored", 8'h24, 32'h07ff_000f, 32'h0008_0006);
    check("out refused", 32'(ep_accept_out), 32'h3d);
    // bank released so a taken packet would show
    axi_wr(8'h24, 32'h4, rs);
    host.pulse(4, 6'h02, 11'h003);
    rchk("out ignored", 8'h24, 32'h07ff_000f, 32'h0008_0004);
    host.pulse(3, 6'h02, 11'h0);
    axi_wr(`OFS_EP_FIFO_RESET, 32'h2, rs);
    check("fifo held", 32'(ep_fifo_clear), 32'h2);
    rchk("ep reset", 8'h24, 32'h07ff_080f, 32'h0000_0005);
    rchk("reset readback", `OFS_EP_FIFO_RESET, 32'h3f, 32'h2);
    axi_wr(`OFS_EP_FIFO_RESET, 32'h0, rs);
    check("fifo released", 32'(ep_fifo_clear), 32'h0);
    axi_wr(8'h24, 32'h0, rs);
    check("out accepted", 32'(ep_accept_out), 32'h3f);
    host.pulse(6, 6'h02, 11'h0);
    rchk("stall ack", 8'h24, 32'hf, 32'h8);
    axi_wr(8'h24, 32'h0, rs);
    rchk("stall cleared", 8'h24, 32'hf, 32'h0);
    axi_wr(8'h28, 32'h0000_8100, rs);
    host.pulse(7, 6'h06, 11'h0);
    rchk("iso crc", 8'h28, 32'hf, 32'h8);
    rchk("crc non iso", 8'h24, 32'hf, 32'h0);
    rchk("kind on", 8'h28, 32'h8f00, 32'h8100);
    axi_wr(8'h28, 32'h0000_0100, rs);
    rchk("crc cleared", 8'h28, 32'hf, 32'h0);
    axi_wr(`OFS_PORT_CTRL, 32'h1, rs);
    host.go_quiet(1'b1);
    repeat (25) @(posedge sys_clk);
    check("suspended", 32'(suspended), 32'h1);
    local_resume_request <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rchk("suspend and local", `OFS_INT_STATUS, 32'h3f00, 32'h0500);
    check("resume pulses", 32'(n_wake), 32'h1);
    host.go_quiet(1'b0);
    local_resume_request <= 1'b0;
    finish_test();
  end
endmodule
